/* File: src/pwr_seq_pkg.sv */
// Shared constants, types and helpers for the power sequencing timing block.
// Assumes a 50 MHz core clock. Every delay and ramp interval is counted in
// ticks of a 50 us timebase.
package pwr_seq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timebase
   localparam int CLK_MHZ = 50;                      // Core clock rate
   localparam int TICK_US = 50;                      // Finest timing step
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;   // Core cycles per tick
   localparam int TICKW = 9;                         // Holds 320 ticks (16 ms)

   // Supported settings, in microseconds
   localparam int T_50_US = 50;
   localparam int T_500_US = 500;
   localparam int T_1000_US = 1000;
   localparam int T_1500_US = 1500;
   localparam int T_2000_US = 2000;
   localparam int T_4000_US = 4000;
   localparam int T_8000_US = 8000;
   localparam int T_16000_US = 16000;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes and word layout
   localparam logic [7:0] CMD_START_DLY = 8'h60;
   localparam logic [7:0] CMD_RISE = 8'h61;
   localparam logic [7:0] CMD_STOP_DLY = 8'h64;
   localparam logic [4:0] EXP_FIXED = 5'h1f;        // Exponent -1: 0.5 ms step
   localparam logic [7:0] HI_FIXED = 8'hf8;         // Exponent plus zero bits 10:8
   localparam logic [7:0] LO_DLY_MASK = 8'h07;      // Writable bits 2:0
   localparam logic [7:0] LO_RISE_MASK = 8'h3f;     // Writable bits 5:0
   localparam logic [2:0] RST_DLY = 3'h0;
   localparam logic [5:0] RST_RISE = 6'h00;

   // Timing configuration as held and restored
   typedef struct packed {
      logic [2:0] start_m;
      logic [5:0] rise_m;
      logic [2:0] stop_m;
   } timing_cfg_t;

   // Communication fault flags
   typedef struct packed {
      logic cml;
      logic ivd;
   } cml_status_t;

   ////////////////////////////////////////////////////////////////////////////
   // Mantissa to tick maps
   function automatic logic [TICKW-1:0] us2t(input int us);
      return TICKW'(us / TICK_US);
   endfunction

   function automatic logic [TICKW-1:0] start_ticks(input logic [2:0] m);
      case (m)
         3'h0: return us2t(T_50_US);
         3'h1: return us2t(T_500_US);
         3'h2: return us2t(T_1000_US);
         default: return us2t(T_2000_US);
      endcase
   endfunction

   function automatic logic [TICKW-1:0] rise_ticks(input logic [5:0] m);
      if (m[5]) return us2t(T_16000_US);
      else if (m[4]) return us2t(T_8000_US);
      else if (m[3]) return us2t(T_4000_US);
      else if (m[2]) return us2t(T_2000_US);
      else if (m[1]) return us2t(T_1000_US);
      else return us2t(T_500_US);
   endfunction

   // Value 3 falls in two printed ranges; the narrow 1.5 ms row is taken
   function automatic logic [TICKW-1:0] stop_ticks(input logic [2:0] m);
      case (m)
         3'h0: return '0;
         3'h1, 3'h2: return us2t(T_1000_US);
         3'h3: return us2t(T_1500_US);
         default: return us2t(T_2000_US);
      endcase
   endfunction

   // Slew selector 0..5 for the reference ramp
   function automatic logic [2:0] rise_code(input logic [5:0] m);
      if (m[5]) return 3'h5;
      else if (m[4]) return 3'h4;
      else if (m[3]) return 3'h3;
      else if (m[2]) return 3'h2;
      else if (m[1]) return 3'h1;
      else return 3'h0;
   endfunction

   // Canonical restore values: one per hardware setting, but two (0 and 1) for soft-start 0.5 ms
   function automatic logic [2:0] canon_start(input logic [2:0] m);
      return (m > 3'h3) ? 3'h3 : m;
   endfunction

   function automatic logic [5:0] canon_rise(input logic [5:0] m);
      return (m == 6'h00) ? 6'h00 : 6'(6'h01 << rise_code(m));
   endfunction

   function automatic logic [2:0] canon_stop(input logic [2:0] m);
      case (m)
         3'h0: return 3'h0;
         3'h1, 3'h2: return 3'h1;
         3'h3: return 3'h3;
         default: return 3'h4;
      endcase
   endfunction

endpackage

/* File: src/sync2.sv */
// Two flip-flop synchroniser for pin-level inputs.
// Assumes each bit is a slow level; no bus coherence is implied between bits.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0   // Idle level of each pin: no false edge after reset
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   logic [W-1:0] meta_r;   // First stage, read only by q

   // Plain double register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: src/interval_timer.sv */
// Interval timer on a divided timebase: load N ticks, done pulses N ticks later.
// Assumes load is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
   parameter int TICKW = 9,
   parameter int TICK_CYCLES = 2500
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [TICKW-1:0] ticks,
   output var logic done
);
   localparam int PW = $clog2(TICK_CYCLES);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

   // A divider of one cycle would make the tick a constant
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("interval_timer: TICK_CYCLES must be at least 2");
   end

   logic [PW-1:0] pre_r;      // Prescaler, restarted on load for exact spans
   logic [TICKW-1:0] rem_r;   // Ticks still to run
   logic busy_r;
   wire logic tick = busy_r && (pre_r == PRE_LAST);

   // Reload wins over a running interval
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_r <= '0;
         rem_r <= '0;
         busy_r <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         pre_r <= '0;
         rem_r <= ticks;
         busy_r <= (ticks != '0);
         done <= (ticks == '0);
      end else begin
         done <= tick && (rem_r == TICKW'(1));
         pre_r <= (tick || !busy_r) ? '0 : pre_r + PW'(1);
         if (tick) begin
            rem_r <= rem_r - TICKW'(1);
            busy_r <= (rem_r != TICKW'(1));
         end
      end
   end
endmodule
`default_nettype wire

/* File: src/pwr_seq_timing_regs.sv */
// Power sequencing timing words on a two-wire management bus, plus the
// start-delay / ramp / stop-delay sequencer that those words steer.
// Assumes scl/sda and the run and band levels are pins, sampled here.
//
// Notes on behaviour
// - Start condition waits start delay before rising.
// - Exponent bits 15:11 fixed 11111b, read-only.
// - Start mantissa zero still enforces 50 us.
// - Start map 0.05, 0.5, 1, 2 ms.
// - Any mantissa stored; nearest setting applied (soft-start rounds down instead, to 0.5 ms at least).
// - Restore loads canonical mantissa per setting.
// - Read-only change: NACK, discard, set cml, ivd.
// - Soft-start word selects reference ramp slew.
// - Soft-start mantissa bits 5:0, reset zero.
// - Soft-start map 0.5 through 16 ms.
// - Setpoint boot may end the ramp early.
// - Stop condition waits stop delay before soft-stop.
// - Delay mantissas bits 2:0, reset zero.
// - Stop map 0, 1, 1.5, 2 ms.
// - Reserved bits always read zero.
// - Word write and read, effective on the fly.
// - Soft-start from memory or strap; delays memory.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_timing_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2a   // Bus address, arbitrary default
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output var logic sda_out,
   output var logic sda_oe,
   input wire logic run_req,
   input wire logic vout_in_band,
   input wire logic boot_from_setpoint,
   input wire logic nvm_load,
   input wire pwr_seq_pkg::timing_cfg_t nvm_cfg,
   input wire logic strap_load,
   input wire logic [5:0] strap_rise,
   input wire logic cml_clr,
   output var pwr_seq_pkg::timing_cfg_t cfg,
   output var pwr_seq_pkg::cml_status_t cml_stat,
   output var logic [2:0] ramp_sel,
   output var logic rise_go,
   output var logic ramp_active,
   output var logic soft_stop_go
);
   import pwr_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling and bus edge detection
   logic [3:0] pins_s;          // Synchronised scl, sda, run, band
   logic scl_d, sda_d;          // One more stage for edges
   sync2 #(.W(4), .RST_VAL(4'b1100)) u_sync (   // Bus pins idle high, like the edge history
      .ref_clk(ref_clk),
      .rst(rst),
      .d({scl_in, sda_in, run_req, vout_in_band}),
      .q(pins_s)
   );
   wire logic scl_s = pins_s[3];
   wire logic sda_s = pins_s[2];
   wire logic run_s = pins_s[1];
   wire logic band_s = pins_s[0];
   wire logic scl_rise = scl_s && !scl_d;
   wire logic scl_fall = !scl_s && scl_d;
   // Data moving while the clock is high frames a transaction
   wire logic start_det = scl_s && scl_d && sda_d && !sda_s;
   wire logic stop_det = scl_s && scl_d && !sda_d && sda_s;

   // Edge history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte engine state
   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_RX = 3'b001,
      B_ACK = 3'b010,
      B_TX = 3'b011,
      B_RACK = 3'b100
   } bus_st_t;

   bus_st_t bus_st_r;
   logic [7:0] shift_r;     // Receive and transmit shifter
   logic [3:0] bit_cnt_r;   // Bits moved in this byte
   logic [1:0] idx_r;       // 0 address, 1 command, 2 low, 3 high
   logic is_read_r;         // Address byte asked for a read
   logic ack_r;             // This byte is acknowledged
   logic m_ack_r;           // Host acknowledged our byte
   logic tx_hi_r;           // High byte is on its way out
   logic sda_drv_r;         // Pull data low
   logic [7:0] cmd_r;
   logic [7:0] lo_r;
   timing_cfg_t cfg_r;
   logic ivd_r, cml_r;

   ////////////////////////////////////////////////////////////////////////////
   // Byte decode
   wire logic byte_end = (bus_st_r == B_RX) && scl_fall && (bit_cnt_r == 4'h8);
   wire logic addr_hit = (shift_r[7:1] == DEV_ADDR);
   wire logic cmd_known = (shift_r == CMD_START_DLY) || (shift_r == CMD_RISE) ||
                          (shift_r == CMD_STOP_DLY);
   wire logic [7:0] lo_mask = (cmd_r == CMD_RISE) ? LO_RISE_MASK : LO_DLY_MASK;
   // Read-only bits must arrive as they read back
   wire logic lo_ok = ((shift_r & ~lo_mask) == 8'h00);
   wire logic hi_ok = (shift_r == HI_FIXED);
   wire logic byte_ack = (idx_r == 2'h0) ? addr_hit :
                         (idx_r == 2'h1) ? cmd_known :
                         (idx_r == 2'h2) ? lo_ok : hi_ok;
   wire logic wr_data = byte_end && !is_read_r && idx_r[1];
   wire logic ivd_set = wr_data && !byte_ack;
   wire logic commit = wr_data && (idx_r == 2'h3) && hi_ok;

   // Readback word: fixed exponent, zero reserved, stored mantissa
   wire logic [7:0] rd_lo = (cmd_r == CMD_START_DLY) ? {5'h00, cfg_r.start_m} :
                            (cmd_r == CMD_RISE) ? {2'h0, cfg_r.rise_m} :
                            (cmd_r == CMD_STOP_DLY) ? {5'h00, cfg_r.stop_m} :
                            8'h00;
   wire logic [15:0] rd_word = {HI_FIXED, rd_lo};

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: shifts on clock rise, drives data after clock fall
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bus_st_r <= B_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         idx_r <= 2'h0;
         is_read_r <= 1'b0;
         ack_r <= 1'b0;
         m_ack_r <= 1'b0;
         tx_hi_r <= 1'b0;
         sda_drv_r <= 1'b0;
         cmd_r <= 8'h00;
         lo_r <= 8'h00;
      end else if (stop_det) begin
         // Transaction over, release the line
         bus_st_r <= B_IDLE;
         sda_drv_r <= 1'b0;
      end else if (start_det) begin
         // Start or repeated start: expect an address byte
         bus_st_r <= B_RX;
         bit_cnt_r <= 4'h0;
         idx_r <= 2'h0;
         is_read_r <= 1'b0;
         sda_drv_r <= 1'b0;
      end else begin
         case (bus_st_r)
            B_RX: begin
               if (scl_rise && (bit_cnt_r != 4'h8)) begin
                  shift_r <= {shift_r[6:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_end) begin
                  // Refused bytes leave sda released: a NACK
                  ack_r <= byte_ack;
                  sda_drv_r <= byte_ack;
                  bus_st_r <= B_ACK;
                  if (idx_r == 2'h0) is_read_r <= shift_r[0];
                  if (idx_r == 2'h1) cmd_r <= shift_r;
                  if (idx_r == 2'h2) lo_r <= shift_r;
               end
            end
            B_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (!ack_r || (!is_read_r && idx_r == 2'h3)) begin
                     sda_drv_r <= 1'b0;
                     bus_st_r <= B_IDLE;
                  end else if (is_read_r) begin
                     // Word read: low byte first
                     shift_r <= rd_word[7:0];
                     sda_drv_r <= !rd_word[7];
                     tx_hi_r <= 1'b0;
                     bus_st_r <= B_TX;
                  end else begin
                     sda_drv_r <= 1'b0;
                     idx_r <= idx_r + 2'h1;
                     bus_st_r <= B_RX;
                  end
               end
            end
            B_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == 4'h7) begin
                     sda_drv_r <= 1'b0;
                     bus_st_r <= B_RACK;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sda_drv_r <= !shift_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            B_RACK: begin
               if (scl_rise) begin
                  m_ack_r <= !sda_s;
               end else if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (m_ack_r && !tx_hi_r) begin
                     shift_r <= rd_word[15:8];
                     sda_drv_r <= !rd_word[15];
                     tx_hi_r <= 1'b1;
                     bus_st_r <= B_TX;
                  end else begin
                     bus_st_r <= B_IDLE;
                  end
               end
            end
            default: begin
               sda_drv_r <= 1'b0;
            end
         endcase
      end
   end

   assign sda_out = 1'b0;       // Open drain: only ever pulls low
   assign sda_oe = sda_drv_r;

   ////////////////////////////////////////////////////////////////////////////
   // Timing words; restore beats a bus write landing in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg_r <= '{start_m: RST_DLY, rise_m: RST_RISE, stop_m: RST_DLY};
      end else if (nvm_load) begin
         cfg_r.start_m <= canon_start(nvm_cfg.start_m);
         cfg_r.rise_m <= canon_rise(nvm_cfg.rise_m);
         cfg_r.stop_m <= canon_stop(nvm_cfg.stop_m);
      end else begin
         if (strap_load) cfg_r.rise_m <= canon_rise(strap_rise);
         // Any mantissa is kept as written and read back
         if (commit && cmd_r == CMD_START_DLY) cfg_r.start_m <= lo_r[2:0];
         if (commit && cmd_r == CMD_RISE) cfg_r.rise_m <= lo_r[5:0];
         if (commit && cmd_r == CMD_STOP_DLY) cfg_r.stop_m <= lo_r[2:0];
      end
   end

   assign cfg = cfg_r;

   // Sticky fault flags; a new fault beats a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ivd_r <= 1'b0;
         cml_r <= 1'b0;
      end else begin
         ivd_r <= ivd_set || (ivd_r && !cml_clr);
         cml_r <= ivd_set || (cml_r && !cml_clr);
      end
   end

   assign cml_stat = '{cml: cml_r, ivd: ivd_r};

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ON_DLY = 3'b001,
      S_RAMP = 3'b010,
      S_ON = 3'b011,
      S_OFF_DLY = 3'b100
   } seq_st_t;

   seq_st_t seq_r;
   logic tmr_done;
   wire logic active = (seq_r == S_ON_DLY) || (seq_r == S_RAMP) || (seq_r == S_ON);
   wire logic stop_req = active && !run_s;
   wire logic start_req = (seq_r == S_IDLE) && run_s;
   wire logic rise_now = (seq_r == S_ON_DLY) && tmr_done && run_s;
   // Setpoint boot may reach the band before the nominal ramp time
   wire logic ramp_end = (seq_r == S_RAMP) && run_s &&
                         (tmr_done || (boot_from_setpoint && band_s));
   wire logic tmr_load = start_req || rise_now || stop_req;
   // Intervals latch the word at their start; a new word applies to the next
   wire logic [TICKW-1:0] tmr_ticks = stop_req ? stop_ticks(cfg_r.stop_m) :
                                     start_req ? start_ticks(cfg_r.start_m) :
                                     rise_ticks(cfg_r.rise_m);

   interval_timer #(.TICKW(TICKW), .TICK_CYCLES(TICK_CYCLES)) u_tmr (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(tmr_load),
      .ticks(tmr_ticks),
      .done(tmr_done)
   );

   // Delay then ramp on start; delay then soft-stop on stop
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         seq_r <= S_IDLE;
         rise_go <= 1'b0;
         soft_stop_go <= 1'b0;
         ramp_sel <= 3'h0;
      end else begin
         rise_go <= rise_now;
         soft_stop_go <= (seq_r == S_OFF_DLY) && tmr_done;
         if (rise_now) ramp_sel <= rise_code(cfg_r.rise_m);
         case (seq_r)
            S_IDLE: if (start_req) seq_r <= S_ON_DLY;
            S_ON_DLY: begin
               if (stop_req) seq_r <= S_OFF_DLY;
               else if (rise_now) seq_r <= S_RAMP;
            end
            S_RAMP: begin
               if (stop_req) seq_r <= S_OFF_DLY;
               else if (ramp_end) seq_r <= S_ON;
            end
            S_ON: if (stop_req) seq_r <= S_OFF_DLY;
            S_OFF_DLY: if (tmr_done) seq_r <= S_IDLE;
            default: seq_r <= S_IDLE;
         endcase
      end
   end

   assign ramp_active = (seq_r == S_RAMP);

   ////////////////////////////////////////////////////////////////////////////
   // Checks, with cycle counter since the last timer load
   logic [19:0] dly_cnt_r;
   logic [TICKW-1:0] lat_ticks_r;
   wire logic [19:0] span = 20'(lat_ticks_r * TICK_CYCLES);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dly_cnt_r <= 20'h0_0000;
         lat_ticks_r <= '0;
      end else begin
         dly_cnt_r <= tmr_load ? 20'h0_0000 : dly_cnt_r + 20'h0_0001;
         if (tmr_load) lat_ticks_r <= tmr_ticks;
      end
   end

   start_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      rise_go |-> $past(dly_cnt_r) == $past(span))
      else $error("start delay length wrong");
   start_min_a: assert property (@(posedge ref_clk) disable iff (rst)
      rise_go |-> $past(dly_cnt_r) >= 20'(TICK_CYCLES))
      else $error("start delay under minimum");
   stop_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      soft_stop_go |-> dly_cnt_r == span + 20'h0_0001)
      else $error("stop delay length wrong");
   ramp_time_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ramp_active && tmr_done) |-> dly_cnt_r == span)
      else $error("ramp length wrong");
   ro_reject_a: assert property (@(posedge ref_clk) disable iff (rst)
      (ivd_set && !nvm_load && !strap_load) |=>
         !sda_oe && cml_stat.ivd && cml_stat.cml && $stable(cfg_r))
      else $error("bad write not refused");
   readback_a: assert property (@(posedge ref_clk) disable iff (rst)
      (commit && cmd_r == CMD_RISE && !nvm_load && !strap_load) |=>
         cfg_r.rise_m == $past(lo_r[5:0]))
      else $error("written mantissa not kept");
   exp_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
      (bus_st_r == B_TX && tx_hi_r && bit_cnt_r == 4'h0) |-> shift_r[7:3] == EXP_FIXED)
      else $error("exponent not fixed");
   reserved_a: assert property (@(posedge ref_clk) disable iff (rst)
      (bus_st_r == B_TX && !tx_hi_r && bit_cnt_r == 4'h0 && cmd_r != CMD_RISE) |->
         shift_r[7:3] == 5'h00)
      else $error("reserved bits not zero");
   restore_a: assert property (@(posedge ref_clk) disable iff (rst)
      nvm_load |=> $onehot0(cfg_r.rise_m) && cfg_r.stop_m != 3'h2 && cfg_r.start_m <= 3'h3)
      else $error("restore not canonical");
endmodule
`default_nettype wire

/* File: dv/pmbus_host.sv */
// Bus host model: word writes and reads on the two-wire management bus.
// Assumes the bench resolves SDA as a pull-up against pull and the device.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host (
   output var logic scl,
   output var logic pull,
   input wire logic sda
);
   logic [15:0] rdata; // Last word read
   logic [7:0] r; // Unused readback
   logic [3:0] a; // Acks seen
   event got; // Fires when rdata is fresh
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // Start (1) or stop (0); SDA is set up while SCL is low, then moves while SCL is high
   task automatic cond(input logic s);
      scl = 1'b0;
      pull = !s;
      #100 scl = 1'b1;
      #60 pull = s;
      #60 scl = !s;
   endtask
   // Byte and ack slot, 160 ns a bit; late data edge clears the device's ack release
   task automatic xfer(input logic [7:0] v, input logic k, output logic [7:0] q,
         output logic ak);
      for (int j = 0; j < 9; j++) begin
         scl = 1'b0;
         #40 pull = (j == 8) ? k : !v[7 - j];
         #60 scl = 1'b1;
         #30 ak = !sda;
         if (j < 8)
            q[7 - j] = sda;
         #30;
      end
   endtask
   // Word write (rw 0) or read (rw 1), low byte first
   task automatic xact(input logic [7:0] c, input logic rw, input logic [15:0] w,
         output logic ok);
      cond(1'b1);
      xfer(8'h54, 1'b0, r, a[0]);
      xfer(c, 1'b0, r, a[1]);
      if (rw) begin
         cond(1'b1);
         xfer(8'h55, 1'b0, r, a[2]);
      end
      xfer(rw ? 8'hff : w[7:0], rw, rdata[7:0], a[2]);
      xfer(rw ? 8'hff : w[15:8], 1'b0, rdata[15:8], a[3]);
      cond(1'b0);
      ok = &a;
      if (rw)
         ->got;
   endtask
endmodule
`default_nettype wire

/* File: dv/pwr_seq_timing_regs_tb.sv */
// Bench: word access, write faults, restore and the start/stop sequence.
// Assumes the host model for bus traffic and a pull-up on the data line.
`timescale 1ns/1ps
`default_nettype none
module pwr_seq_timing_regs_tb;
   import pwr_seq_pkg::*;
   logic ref_clk = 0, rst = 1, run_req = 0, band = 0, nvm_load = 0, cml_clr = 0, boot = 1;
   logic scl, pull, sda, sda_o, sda_oe, rise_go, ramp_act, stop_go, ok, strap_load = 0;
   timing_cfg_t nvm_cfg = '0, cfg;
   cml_status_t cml_stat;
   logic [2:0] ramp_sel, e;
   logic [5:0] m, strap_rise = 6'h00;
   logic [15:0] exp_q[$];
   int fails = 0, n_compared = 0, seed = 20625, c;
   assign sda = !((sda_oe && !sda_o) || pull);
   initial forever #10 ref_clk = !ref_clk;
   pmbus_host i_pmbus_host (.scl(scl), .pull(pull), .sda(sda));
   pwr_seq_timing_regs i_pwr_seq_timing_regs (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_o), .sda_oe(sda_oe), .run_req(run_req), .vout_in_band(band),
      .boot_from_setpoint(boot), .nvm_load(nvm_load), .nvm_cfg(nvm_cfg), .strap_load(strap_load),
      .strap_rise(strap_rise), .cml_clr(cml_clr), .cfg(cfg), .cml_stat(cml_stat),
      .ramp_sel(ramp_sel), .rise_go(rise_go), .ramp_active(ramp_act), .soft_stop_go(stop_go));
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      n_compared++;
      if (s !== x) begin
         fails++;
         $display("BAD %0t: got %h, want %h", $time, s, x);
      end
   endtask
   task automatic print_verdict();
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Note the expected word, then read; the watcher compares
   task automatic rdx(input logic [7:0] a, input logic [15:0] x);
      exp_q.push_back(x);
      i_pmbus_host.xact(a, 1'b1, 16'h0000, ok);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] w, input logic x);
      i_pmbus_host.xact(a, 1'b0, w, ok);
      chk(ok, x);
   endtask
   // Bounded wait, in cycles, for s to reach v
   task automatic waitc(ref logic s, input logic v, input int lim);
      c = 0;
      while (s !== v && c < lim) begin
         @(posedge ref_clk);
         #1 c++;
      end
   endtask
   always @(i_pmbus_host.got) chk(i_pmbus_host.rdata, exp_q.pop_front());
   initial begin
      #2_000_000 fails++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      #1 rst = 1'b0;
      chk(cfg, 16'h0000);
      rdx(8'h60, 16'hf800);
      rdx(8'h61, 16'hf800);
      rdx(8'h64, 16'hf800);
      wr(8'h60, 16'hf805, 1'b1);
      rdx(8'h60, 16'hf805);
      wr(8'h64, 16'hf840, 1'b0);
      chk(cml_stat, 16'h0003);
      wr(8'h60, 16'hf902, 1'b0);
      rdx(8'h60, 16'hf805);
      cml_clr = 1'b1;
      @(posedge ref_clk);
      #1 cml_clr = 1'b0;
      chk(cml_stat, 16'h0000);
      nvm_cfg = {3'h0, 6'h05, 3'h0};
      nvm_load = 1'b1;
      @(posedge ref_clk);
      #1 nvm_load = 1'b0;
      chk(cfg, {4'h0, 3'h0, 6'h04, 3'h0});
      strap_rise = 6'h0b;
      strap_load = 1'b1;
      @(posedge ref_clk);
      #1 strap_load = 1'b0;
      chk(cfg, {4'h0, 3'h0, 6'h08, 3'h0});
      // Random soft-start words; the band input cuts each ramp short
      for (int i = 0; i < 3; i++) begin
         m = 6'($random(seed));
         wr(8'h61, {10'h3e0, m}, 1'b1);
         e = 3'h0;
         for (int k = 1; k < 6; k++)
            if (m[k])
               e = 3'(k);
         @(posedge ref_clk);
         #1 run_req = 1'b1;
         waitc(rise_go, 1'b1, 3000);
         chk(16'(c >= 2501 && c <= 2506), 16'h0001);
         chk(ramp_sel, e);
         chk(ramp_act, 1'b1);
         band = 1'b1;
         waitc(ramp_act, 1'b0, 8);
         chk(16'(c < 8), 16'h0001);
         run_req = 1'b0;
         waitc(stop_go, 1'b1, 20);
         chk(16'(c < 20), 16'h0001);
         band = 1'b0;
      end
      // Full-length ramp: no setpoint boot, shortest setting 0.5 ms
      boot = 1'b0;
      wr(8'h61, 16'hf801, 1'b1);
      @(posedge ref_clk);
      #1 run_req = 1'b1;
      waitc(rise_go, 1'b1, 3000);
      chk(ramp_sel, 3'h0);
      waitc(ramp_act, 1'b0, 26000);
      chk(16'(c >= 25000 && c <= 25002), 16'h0001);
      print_verdict();
   end
endmodule
`default_nettype wire
